// ### common/phy_strap_consts.vh
`ifndef PHY_STRAP_CONSTS_VH
`define PHY_STRAP_CONSTS_VH

// Register byte addresses (APB, one aligned word each)
`define REG_CTRL_ADDR 12'h000
`define REG_LED_ADDR 12'h004
`define REG_STAT_ADDR 12'h008

// Control word: speed select position (1 = 100 Mb/s)
`define CTRL_SPEED_BIT 13
// LED control word: two-bit mode field
`define LED_MODE_HI 15
`define LED_MODE_LO 14
`define LED_MODE_SPEED 2'h0
`define LED_MODE_ACT 2'h1

// Status word layout
`define STAT_ADDR_HI 4
`define STAT_ADDR_LO 0
`define STAT_MODE_HI 7
`define STAT_MODE_LO 5
`define STAT_ISO_BIT 8
`define STAT_RMII_BIT 9
`define STAT_DONE_BIT 10

// Strap decoding
`define MODE_RMII 3'h1
`define ADDR_TOP_ZERO 2'h0

// Reset values
`define LED_MODE_RST 2'h0
`define WORD_ZERO 32'h00000000

// Reference clock half period in pclk cycles (4 cycles = 160 ns at 25 MHz)
`define REF_HALF_CYC 4
// Synchroniser settle cycles before the strap capture
`define STRAP_SETTLE 2'h3
// Activity blink half period in reference clock ticks
`define BLINK_TICKS 16

`endif

// ### src/phy_strap_latch_led_rmii_pins.v
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// (R01) LED mode field picks speed or activity
// (R02) Speed strap loads control speed bit
// (R03) Strap pins input in reset, driven after
// (R04) Receive dibit presented each valid reference cycle
// (R05) MAC drives transmit dibit while enable high
// (R06) Management address captured from three straps
// (R07) Default pulls give management address 00001
// (R08) Address top two bits always zero
// (R09) Mode strap latched; only 001 is RMII
// (R10) Isolate strap high enables isolate mode
// (R11) Device drives the reference clock out
// (R12) Straps captured at reset release, then held
`include "phy_strap_consts.vh"

module phy_strap_latch_led_rmii_pins #(
  parameter REF_HALF = `REF_HALF_CYC,
  parameter BLINK = `BLINK_TICKS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg pslverr,
  output reg [31:0] prdata,
  // Speed strap / second LED pin
  input wire second_led_in,
  output reg second_led_out,
  output reg second_led_oe_n,
  // Address and mode strap pins, bit order 2..0
  input wire [2:0] mgmt_addr_strap_in,
  output reg [2:0] mgmt_addr_strap_out,
  output reg [2:0] mgmt_addr_strap_oe_n,
  input wire [2:0] if_mode_strap_in,
  output reg [2:0] if_mode_strap_out,
  output reg [2:0] if_mode_strap_oe_n,
  // Isolate strap pin
  input wire iso_strap_in,
  output reg iso_strap_out,
  output reg iso_strap_oe_n,
  // RMII link to the MAC
  output reg ref_clk,
  input wire tx_en,
  input wire [1:0] txd,
  output reg crs_dv,
  output reg [1:0] rxd,
  // User side: receive source and transmit sink
  input wire rx_frame,
  input wire [1:0] rx_dibit,
  output reg tx_valid,
  output reg [1:0] tx_dibit
);

  // Two-flop synchronisers for the strap pins and the MAC transmit pins
  reg [10:0] sync1_q; // First stage, read only by second
  reg [10:0] sync2_q; // Stable pin levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
    end else begin
      sync1_q <= {tx_en, txd, iso_strap_in, if_mode_strap_in, mgmt_addr_strap_in, second_led_in};
      sync2_q <= sync1_q;
    end
  end

  // Named views of synchronised pins
  wire speed_pin = sync2_q[0];
  wire [2:0] addr_pin = sync2_q[3:1];
  wire [2:0] mode_pin = sync2_q[6:4];
  wire iso_pin = sync2_q[7];
  wire [1:0] txd_s = sync2_q[9:8];
  wire tx_en_s = sync2_q[10];

  // Strap capture state
  reg [1:0] settle_q; // Cycles since reset release
  reg done_q; // Straps captured
  reg speed_q; // Control speed select
  reg [4:0] addr_q; // Management address
  reg [2:0] mode_q; // Interface mode
  reg iso_q; // Isolate enable
  wire rmii_ok = (mode_q == `MODE_RMII);

  // Capture straps once, after synchronisers settle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 2'h0;
      done_q <= 1'b0;
      addr_q <= 5'h00;
      mode_q <= 3'h0;
      iso_q <= 1'b0;
    end else if (!done_q) begin
      if (settle_q == `STRAP_SETTLE) begin
        done_q <= 1'b1; // (R12)
        addr_q <= {`ADDR_TOP_ZERO, addr_pin}; // (R06) (R07) (R08)
        mode_q <= mode_pin; // (R09)
        iso_q <= iso_pin; // (R10)
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // Reference clock divider, driven out to the MAC
  reg [7:0] div_q; // Half period counter
  reg rise_q; // One-cycle pulse on each reference rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      ref_clk <= 1'b0;
      rise_q <= 1'b0;
    end else if (div_q == REF_HALF[7:0] - 8'h01) begin
      div_q <= 8'h00;
      ref_clk <= ~ref_clk; // (R11)
      rise_q <= ~ref_clk;
    end else begin
      div_q <= div_q + 8'h01;
      rise_q <= 1'b0;
    end
  end

  // Receive path: changes only on reference rising edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs_dv <= 1'b0;
      rxd <= 2'h0;
    end else if (rise_q) begin
      // Isolate or non-RMII mode keeps the receive path quiet
      if (done_q && rmii_ok && !iso_q && rx_frame) begin
        crs_dv <= 1'b1; // (R04)
        rxd <= rx_dibit; // (R04)
      end else begin
        crs_dv <= 1'b0;
        rxd <= 2'h0;
      end
    end
  end

  // Transmit path: both bits taken each enabled reference cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_dibit <= 2'h0;
    end else begin
      tx_valid <= rise_q && tx_en_s && done_q && rmii_ok && !iso_q; // (R05)
      if (rise_q && tx_en_s) begin
        tx_dibit <= txd_s; // (R05)
      end
    end
  end

  // Activity blink: toggles every BLINK reference ticks while busy
  reg [7:0] blink_cnt_q; // Tick counter
  reg blink_q; // Blink phase
  wire busy = tx_en_s | crs_dv;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= 8'h00;
      blink_q <= 1'b0;
    end else if (!busy) begin
      blink_cnt_q <= 8'h00;
      blink_q <= 1'b0;
    end else if (rise_q) begin
      if (blink_cnt_q == BLINK[7:0] - 8'h01) begin
        blink_cnt_q <= 8'h00;
        blink_q <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 8'h01;
      end
    end
  end

  // Registers written by software
  reg [1:0] led_mode_q; // Second LED function
  wire setup = psel & ~penable;
  wire access = psel & penable & ~pready;
  wire hit_ctrl = (paddr == `REG_CTRL_ADDR);
  wire hit_led = (paddr == `REG_LED_ADDR);
  wire hit_stat = (paddr == `REG_STAT_ADDR);
  wire hit_any = hit_ctrl | hit_led | hit_stat;
  // Writes land on the edge at which the master sees pready
  wire wr_commit = psel & penable & pready & pwrite;

  // Speed select: strap capture wins, software may rewrite later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_q <= 1'b0;
      led_mode_q <= `LED_MODE_RST;
    end else if (!done_q) begin
      if (settle_q == `STRAP_SETTLE) begin
        speed_q <= speed_pin; // (R02)
      end
    end else if (wr_commit) begin
      if (hit_ctrl) begin
        speed_q <= pwdata[`CTRL_SPEED_BIT];
      end
      if (hit_led) begin
        led_mode_q <= pwdata[`LED_MODE_HI:`LED_MODE_LO];
      end
    end
  end

  // Read data mux
  reg [31:0] rd_word;
  always @* begin
    rd_word = `WORD_ZERO;
    if (hit_ctrl) begin
      rd_word[`CTRL_SPEED_BIT] = speed_q;
    end else if (hit_led) begin
      rd_word[`LED_MODE_HI:`LED_MODE_LO] = led_mode_q;
    end else if (hit_stat) begin
      rd_word[`STAT_ADDR_HI:`STAT_ADDR_LO] = addr_q;
      rd_word[`STAT_MODE_HI:`STAT_MODE_LO] = mode_q;
      rd_word[`STAT_ISO_BIT] = iso_q;
      rd_word[`STAT_RMII_BIT] = rmii_ok;
      rd_word[`STAT_DONE_BIT] = done_q;
    end
  end

  // APB answer: one wait state, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `WORD_ZERO;
    end else begin
      pready <= access;
      pslverr <= access & ~hit_any;
      if (access && !pwrite) begin
        prdata <= rd_word;
      end else if (setup) begin
        prdata <= `WORD_ZERO;
      end
    end
  end

  // Pin drive: inputs during reset and until the straps are captured, outputs afterwards
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_led_oe_n <= 1'b1; // (R03)
      mgmt_addr_strap_oe_n <= 3'h7;
      if_mode_strap_oe_n <= 3'h7;
      iso_strap_oe_n <= 1'b1;
      second_led_out <= 1'b1;
      mgmt_addr_strap_out <= 3'h0;
      if_mode_strap_out <= 3'h0;
      iso_strap_out <= 1'b0;
    end else if (done_q) begin
      second_led_oe_n <= 1'b0; // (R03)
      mgmt_addr_strap_oe_n <= 3'h0;
      if_mode_strap_oe_n <= 3'h0;
      iso_strap_oe_n <= 1'b0;
      case (led_mode_q)
        `LED_MODE_SPEED: second_led_out <= ~speed_q; // (R01)
        `LED_MODE_ACT: second_led_out <= ~blink_q; // (R01)
        default: second_led_out <= 1'b1;
      endcase
    end
  end

endmodule

// ### testbench/mac_model.sv
`timescale 1ns/1ps
module mac_model (
  // Reference clock and request
  input wire ref_clk,
  input wire en,
  // Transmit pins
  output logic tx_en,
  output logic [1:0] txd
);
  initial begin
    tx_en = 1'b0;
    txd = 2'h0;
  end
  // Counting dibits while sending, inverted stale value when idle
  always @(posedge ref_clk) begin
    tx_en <= en;
    txd <= en ? txd + 2'h1 : ~txd;
  end
endmodule

// ### testbench/phy_strap_latch_led_rmii_pins_tb.sv
`timescale 1ns/1ps
`include "phy_strap_consts.vh"
module phy_strap_latch_led_rmii_pins_tb;
  logic pclk, presetn, psel, penable, pwrite, led_p, iso_p, rx_frame, en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [2:0] addr_p, mode_p;
  logic [1:0] rx_dibit, last;
  integer failures = 0;
  integer tests_run = 0;
  wire pready, pslverr, second_led_out, second_led_oe_n, iso_strap_out, iso_strap_oe_n;
  wire ref_clk, tx_en, crs_dv, tx_valid;
  wire [31:0] prdata;
  wire [1:0] txd, rxd, tx_dibit;
  wire [2:0] mgmt_addr_strap_out, mgmt_addr_strap_oe_n, if_mode_strap_out, if_mode_strap_oe_n;
  // Pin level: pull while released, device value while driven
  wire second_led_in = second_led_oe_n ? led_p : second_led_out;
  wire iso_strap_in = iso_strap_oe_n ? iso_p : iso_strap_out;
  wire [2:0] mgmt_addr_strap_in = mgmt_addr_strap_oe_n & addr_p | ~mgmt_addr_strap_oe_n & mgmt_addr_strap_out;
  wire [2:0] if_mode_strap_in = if_mode_strap_oe_n & mode_p | ~if_mode_strap_oe_n & if_mode_strap_out;
  phy_strap_latch_led_rmii_pins #(.BLINK(2)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .second_led_in, .second_led_out,
    .second_led_oe_n, .mgmt_addr_strap_in, .mgmt_addr_strap_out, .mgmt_addr_strap_oe_n,
    .if_mode_strap_in, .if_mode_strap_out, .if_mode_strap_oe_n, .iso_strap_in, .iso_strap_out,
    .iso_strap_oe_n, .ref_clk, .tx_en, .txd, .crs_dv, .rxd, .rx_frame, .rx_dibit, .tx_valid,
    .tx_dibit);
  mac_model i_mac (.ref_clk, .en, .tx_en, .txd);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One bus transfer, waiting for the slave under a bound
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n = n + 1;
    end
    if (n == 20) begin
      $display("ERROR %0t: bus answer timed out", $time);
      failures = failures + 1;
      give_verdict;
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  // Reset with given pulls, then check the captured state
  task rst_strap(input [2:0] a, input [2:0] m, input i, input s, input [31:0] st);
    {presetn, addr_p, mode_p, iso_p, led_p} <= {1'b0, a, m, i, s};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(0, `REG_STAT_ADDR, 0);
    chk(rd, st);
    apb(0, `REG_CTRL_ADDR, 0);
    chk(rd, {18'h0, s, 13'h0});
    chk(second_led_out, !s);
    chk({second_led_oe_n, mgmt_addr_strap_oe_n, if_mode_strap_oe_n, iso_strap_oe_n}, 0);
    chk({mgmt_addr_strap_out, if_mode_strap_out, iso_strap_out}, 0);
    $display("strap test done");
  endtask
  // Receive and transmit dibits, or none when the path is off
  task link(input on);
    integer n, k;
    {rx_frame, rx_dibit, en} <= {1'b1, 2'h2, 1'b1};
    repeat (24) @(posedge pclk);
    chk({crs_dv, rxd}, on ? 3'h6 : 3'h0);
    n = 0;
    for (k = 0; k < 32; k = k + 1) begin
      @(posedge pclk);
      if (tx_valid === 1'b1) begin
        if (n > 0) chk(tx_dibit, 2'(last + 2'h1));
        last = tx_dibit;
        n = n + 1;
      end
    end
    chk(n, on ? 4 : 0);
    {rx_frame, en} <= 2'h0;
    repeat (24) @(posedge pclk);
    chk(crs_dv, 0);
    $display("link test done");
  endtask
  // LED modes, activity blink and an unmapped write
  task led_regs;
    integer k, c;
    apb(1, `REG_LED_ADDR, 32'h4000);
    apb(0, `REG_LED_ADDR, 0);
    chk(rd, 32'h4000);
    chk(second_led_out, 1);
    en <= 1'b1;
    c = 0;
    for (k = 0; k < 64; k = k + 1) begin
      @(posedge pclk);
      if (k > 0 && second_led_out !== last[0]) c = c + 1;
      last[0] = second_led_out;
    end
    chk(c >= 2, 1);
    en <= 1'b0;
    apb(1, 12'h00c, 32'h1);
    chk(err, 1);
    apb(1, `REG_CTRL_ADDR, 32'h2000);
    apb(1, `REG_LED_ADDR, 32'h8000);
    repeat (2) @(posedge pclk);
    chk(second_led_out, 1);
    apb(1, `REG_LED_ADDR, 0);
    repeat (2) @(posedge pclk);
    chk(second_led_out, 0);
    apb(1, `REG_CTRL_ADDR, 0);
    repeat (2) @(posedge pclk);
    chk(second_led_out, 1);
    $display("led test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, iso_p, rx_frame, en, rx_dibit, paddr, pwdata} = '0;
    {led_p, addr_p, mode_p} = 7'h48;
    rst_strap(3'h5, 3'h1, 1'b0, 1'b1, 32'h625);
    link(1);
    led_regs;
    rst_strap(3'h1, 3'h0, 1'b0, 1'b1, 32'h401);
    link(0);
    rst_strap(3'h7, 3'h1, 1'b1, 1'b0, 32'h727);
    link(0);
    give_verdict;
  end
endmodule

// ### testbench/strap_pins_chk_assertions.sv
`timescale 1ns/1ps
`include "phy_strap_consts.vh"
module strap_pins_chk #(parameter REF_HALF = 4) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  // Pins and link
  input wire second_led_oe_n,
  input wire ref_clk,
  input wire crs_dv,
  input wire [1:0] rxd,
  input wire tx_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cnt_q;
  logic seen_q;
  // Cycles since the last reference clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h0;
      seen_q <= 1'b0;
    end else if ($changed(ref_clk)) begin
      cnt_q <= 8'h0;
      seen_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
  // Access phase still waiting, and a status read completing
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_stat;
    pready && !pwrite && paddr == `REG_STAT_ADDR;
  endsequence
  AST_OE_HOLD: assert property ($rose(presetn) |-> second_led_oe_n [*3])
    else $error("strap pin driven too early");
  AST_OE_KEEP: assert property (!second_led_oe_n |=> !second_led_oe_n)
    else $error("strap pin released after capture");
  AST_REF_HALF: assert property ($changed(ref_clk) && seen_q |-> cnt_q == REF_HALF - 1)
    else $error("reference clock half period wrong");
  AST_RX_EDGE: assert property ($changed({crs_dv, rxd}) |-> $past(ref_clk) && !$past(ref_clk, 2))
    else $error("receive pins moved off the reference edge");
  AST_TXV_EDGE: assert property (tx_valid |-> $past(ref_clk) && !$past(ref_clk, 2))
    else $error("transmit dibit off the reference edge");
  AST_TXV_PULSE: assert property (tx_valid |=> !tx_valid)
    else $error("transmit strobe longer than one cycle");
  AST_APB_WAIT: assert property (s_acc |=> pready)
    else $error("bus answer late");
  AST_ADDR_TOP: assert property (s_stat |-> prdata[4:3] == `ADDR_TOP_ZERO)
    else $error("address top bits not zero");
  AST_MODE_FLAG: assert property (s_stat |-> prdata[9] == (prdata[7:5] == `MODE_RMII))
    else $error("mode flag disagrees with mode");
  AST_RX_OFF: assert property (s_stat ##0 (!prdata[9] || prdata[8]) |=> !crs_dv)
    else $error("receive active while disabled");
endmodule
bind phy_strap_latch_led_rmii_pins strap_pins_chk #(.REF_HALF(REF_HALF)) i_chk (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .second_led_oe_n, .ref_clk,
  .crs_dv, .rxd, .tx_valid);
